// *** core/adcsq_top.sv ***
// converter sequencer: ahb-lite registers, group sequencing, calibration, dma
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // analog converter
  input wire logic [adcsq_pkg::RES_W-1:0] ana_result,
  output logic ana_power,
  output logic [3:0] ana_channel,
  output logic ana_sample,
  output logic ana_convert,
  output logic ana_cal_run,
  output logic ana_cal_level,
  // dma handshake
  input wire logic dma_ack,
  output logic dma_req
);
  import adcsq_pkg::*;

  typedef struct packed {
    adcsq_state_t state;
    logic pwr;
    logic cal;
    logic cal_init;
    logic dma_en;
    logic align;
    logic cal_lvl;
    logic [1:0] presc;
    logic [NCH-1:0][2:0] smp;
    logic [RSLOTS-1:0][3:0] rseq;
    logic [3:0] rlen;
    logic [ISLOTS-1:0][3:0] iseq;
    logic [1:0] ilen;
    logic [ISLOTS-1:0][RES_W-1:0] iofs;
    logic [ISLOTS-1:0][15:0] ires;
    logic [15:0] rres;
    logic eoc;
    logic jeoc;
    logic reg_pend;
    logic inj_pend;
    logic inj;
    logic [3:0] idx;
    logic [7:0] cnt;
    logic [RES_W-1:0] res_m;
    logic [RES_W-1:0] res_s;
    logic dma_req;
    logic [3:0] chan;
    logic sampling;
    logic converting;
    logic cal_run;
    logic wr_pend;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic hreadyout;
  } adcsq_state_s_t;

  adcsq_state_s_t s;
  adcsq_state_s_t n;
  logic tick;

  adcsq_clkdiv u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(s.pwr),
    .prescale(s.presc),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [3:0] slot_chan(input adcsq_state_s_t st, input logic [3:0] i);
    slot_chan = st.inj ? st.iseq[i[1:0]] : st.rseq[i];
  endfunction

  // codes above nine have no input; they sample for the shortest time
  function automatic logic [7:0] smp_ticks(input adcsq_state_s_t st, input logic [3:0] ch);
    logic [2:0] sel;
    sel = (ch < 4'(NCH)) ? st.smp[ch] : 3'h0;
    smp_ticks = SMP_BASE + 8'(sel * SMP_STEP);
  endfunction

  function automatic logic [31:0] rd_word(input adcsq_state_s_t st, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      OFS_STATUS: begin
        w[B_EOC] = st.eoc;
        w[B_JEOC] = st.jeoc;
        w[B_BUSY] = (st.state != ST_OFF) && (st.state != ST_IDLE);
      end
      OFS_CTRL1: w[B_CALSEL] = st.cal_lvl;
      OFS_CTRL2: begin
        w[B_PWR] = st.pwr;
        w[B_CAL] = st.cal;
        w[B_CALINIT] = st.cal_init;
        w[B_DMA] = st.dma_en;
        w[B_ALIGN] = st.align;
      end
      OFS_SMP1: w[5:0] = {st.smp[9], st.smp[8]};
      OFS_SMP2: w[23:0] = st.smp[7:0];
      OFS_RSEQ1: w = {12'h000, st.rlen, st.rseq[15:12]};
      OFS_RSEQ2: w[23:0] = st.rseq[11:6];
      OFS_RSEQ3: w[23:0] = st.rseq[5:0];
      OFS_ISEQ: w = {14'h0000, st.ilen, st.iseq};
      OFS_RRES: w[15:0] = st.rres;
      OFS_PRESC: w[1:0] = st.presc;
      default: begin
        for (int k = 0; k < ISLOTS; k++) begin
          if (a == OFS_IOFS0 + 8'(4 * k)) begin
            w[RES_W-1:0] = st.iofs[k];
          end
          if (a == OFS_IRES0 + 8'(4 * k)) begin
            w[15:0] = st.ires[k];
          end
        end
      end
    endcase
    rd_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic set_eoc;
    logic set_jeoc;
    logic set_dma;
    logic clr_eoc;
    logic clr_jeoc;
    logic seq_wr;
    logic done;
    logic [RES_W:0] diff;
    logic [3:0] last;
    n = s;
    set_eoc = 1'b0;
    set_jeoc = 1'b0;
    set_dma = 1'b0;
    clr_eoc = 1'b0;
    clr_jeoc = 1'b0;
    seq_wr = 1'b0;
    done = 1'b0;
    diff = '0;
    last = s.inj ? {2'h0, s.ilen} : s.rlen;

    // result pins are asynchronous to hclk
    n.res_m = ana_result;
    n.res_s = s.res_m;

    // sequencer; counts advance on converter ticks, idle leaves on any clock
    unique case (s.state)
      ST_OFF: n.cnt = 8'h00;
      ST_IDLE: begin
        if (s.cal_init) begin
          n.state = ST_CALINIT;
          n.cnt = CALINIT_TICKS;
        end else if (s.cal) begin
          n.state = ST_CAL;
          n.cnt = CAL_TICKS;
        end else if (s.inj_pend || s.reg_pend) begin
          // injected takes precedence when both wait
          n.inj = s.inj_pend;
          n.idx = 4'h0;
          n.state = ST_SAMPLE;
        end
      end
      ST_CALINIT: begin
        if (tick) begin
          n.cnt = s.cnt - 8'h01;
          if (s.cnt == 8'h01) begin
            n.cal_init = 1'b0;
            n.state = ST_IDLE;
          end
        end
      end
      ST_CAL: begin
        if (tick) begin
          n.cnt = s.cnt - 8'h01;
          if (s.cnt == 8'h01) begin
            n.cal = 1'b0;
            n.rres = {6'h00, s.res_s};
            n.state = ST_IDLE;
          end
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          n.cnt = s.cnt - 8'h01;
          if (s.cnt == 8'h01) begin
            n.state = ST_CONV;
            n.cnt = CONV_TICKS;
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          n.cnt = s.cnt - 8'h01;
          if (s.cnt == 8'h01) begin
            if (s.inj) begin
              diff = {1'b0, s.res_s} - {1'b0, s.iofs[s.idx[1:0]]};
              n.ires[s.idx[1:0]] = s.align ? {diff, 5'h00} : {{5{diff[RES_W]}}, diff};
              set_jeoc = 1'b1;
            end else begin
              n.rres = s.align ? {s.res_s, 6'h00} : {6'h00, s.res_s};
              set_dma = s.dma_en;
            end
            set_eoc = 1'b1;
            if (s.idx == last) begin
              done = 1'b1;
              n.state = ST_IDLE;
              if (s.inj) begin
                n.inj_pend = 1'b0;
              end else begin
                n.reg_pend = 1'b0;
              end
            end else begin
              n.idx = s.idx + 4'h1;
              n.state = ST_SAMPLE;
            end
          end
        end
      end
      default: n.state = ST_OFF;
    endcase

    // bus data phase
    if (s.wr_pend) begin
      unique case (s.addr)
        OFS_STATUS: begin
          clr_eoc = !hwdata[B_EOC];
          clr_jeoc = !hwdata[B_JEOC];
        end
        OFS_CTRL1: n.cal_lvl = hwdata[B_CALSEL];
        OFS_CTRL2: begin
          n.dma_en = hwdata[B_DMA];
          n.align = hwdata[B_ALIGN];
          if (!hwdata[B_PWR]) begin
            n.pwr = 1'b0;
            n.state = ST_OFF;
            n.cal = 1'b0;
            n.cal_init = 1'b0;
            n.reg_pend = 1'b0;
            n.inj_pend = 1'b0;
          end else if (!s.pwr) begin
            n.pwr = 1'b1;
            n.state = ST_IDLE;
          end else begin
            n.reg_pend = 1'b1;
            if (hwdata[B_CAL]) begin
              n.cal = 1'b1;
            end
            if (hwdata[B_CALINIT]) begin
              n.cal_init = 1'b1;
            end
            if (hwdata[B_ISTART]) begin
              n.inj_pend = 1'b1;
            end
            // a write that only sets calibration bits is no start
            if (hwdata[B_CAL] || hwdata[B_CALINIT] || hwdata[B_ISTART]) begin
              n.reg_pend = s.reg_pend && !done;
            end
          end
        end
        OFS_SMP1: n.smp[9:8] = hwdata[5:0];
        OFS_SMP2: n.smp[7:0] = hwdata[23:0];
        OFS_RSEQ1: begin
          n.rseq[15:12] = hwdata[15:0];
          n.rlen = hwdata[B_RLEN+:4];
          seq_wr = 1'b1;
        end
        OFS_RSEQ2: begin
          n.rseq[11:6] = hwdata[23:0];
          seq_wr = 1'b1;
        end
        OFS_RSEQ3: begin
          n.rseq[5:0] = hwdata[23:0];
          seq_wr = 1'b1;
        end
        OFS_ISEQ: begin
          n.iseq = hwdata[15:0];
          n.ilen = hwdata[B_ILEN+:2];
          seq_wr = 1'b1;
        end
        OFS_PRESC: n.presc = hwdata[1:0];
        default: begin
          for (int k = 0; k < ISLOTS; k++) begin
            if (s.addr == OFS_IOFS0 + 8'(4 * k)) begin
              n.iofs[k] = hwdata[RES_W-1:0];
            end
          end
        end
      endcase
    end

    // group restart when any sequence register is written under it
    if (seq_wr && (s.state == ST_SAMPLE || s.state == ST_CONV) && n.pwr) begin
      n.state = ST_SAMPLE;
      n.idx = 4'h0;
      set_eoc = 1'b0;
      set_jeoc = 1'b0;
      set_dma = 1'b0;
      n.rres = s.rres;
      n.ires = s.ires;
    end

    // sample count loaded on every entry into sampling
    if (n.state == ST_SAMPLE && (s.state != ST_SAMPLE || n.idx != s.idx || seq_wr)) begin
      n.cnt = smp_ticks(n, slot_chan(n, n.idx));
    end

    // hardware set wins over software clear
    n.eoc = (s.eoc && !clr_eoc) || set_eoc;
    n.jeoc = (s.jeoc && !clr_jeoc) || set_jeoc;
    n.dma_req = (s.dma_req && !dma_ack) || set_dma;

    n.chan = slot_chan(n, n.idx);
    n.sampling = (n.state == ST_SAMPLE);
    n.converting = (n.state == ST_CONV);
    n.cal_run = (n.state == ST_CAL);

    // bus address phase, read data built from the updated copy
    n.hreadyout = 1'b1;
    n.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.addr = {haddr[7:2], 2'h0};
      n.wr_pend = hwrite;
      n.hrdata = hwrite ? 32'h0000_0000 : rd_word(n, n.addr);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.state <= ST_OFF;
      s.presc <= PRESC_RST;
      s.hreadyout <= 1'b1;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  // every transfer completes okay, so the response never moves
  assign hresp = 1'b0;
  assign ana_power = s.pwr;
  assign ana_channel = s.chan;
  assign ana_sample = s.sampling;
  assign ana_convert = s.converting;
  assign ana_cal_run = s.cal_run;
  assign ana_cal_level = s.cal_lvl;
  assign dma_req = s.dma_req;
endmodule
`default_nettype wire

// *** include/adcsq_pkg.sv ***
// constants, field positions and types shared by the converter sequencer
// How it works
// - first power-on write powers up, second starts
// - writing power bit zero aborts, powers down
// - bus registers on hclk, converter on divided ticks
// - ten sources, any order in groups
// - regular group up to sixteen, four-bit length
// - injected group up to four, two-bit length
// - sequence write mid-conversion aborts and restarts group
// - channel eight reference, nine two-level calibration source
// - calibration init bit cleared by hardware when done
// - calibration bit cleared at end, code to result
// - per-channel three-bit sample time selector
// - conversion lasts sample time plus eleven ticks
// - regular end raises one dma request when enabled
// - injected conversions never raise dma requests
// - alignment bit picks right or left placement
// - regular result raw unsigned ten bits
// - injected result minus offset, sign extended when right-aligned
// - regular completion stores result, sets end flag
package adcsq_pkg;
  localparam int RES_W = 10;
  localparam int NCH = 10;
  localparam int RSLOTS = 16;
  localparam int ISLOTS = 4;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_CTRL2 = 8'h08;
  localparam logic [7:0] OFS_SMP1 = 8'h0C;
  localparam logic [7:0] OFS_SMP2 = 8'h10;
  localparam logic [7:0] OFS_RSEQ1 = 8'h14;
  localparam logic [7:0] OFS_RSEQ2 = 8'h18;
  localparam logic [7:0] OFS_RSEQ3 = 8'h1C;
  localparam logic [7:0] OFS_ISEQ = 8'h20;
  localparam logic [7:0] OFS_IOFS0 = 8'h24;
  localparam logic [7:0] OFS_IRES0 = 8'h34;
  localparam logic [7:0] OFS_RRES = 8'h44;
  localparam logic [7:0] OFS_PRESC = 8'h48;
  // status bits
  localparam int B_EOC = 1;
  localparam int B_JEOC = 2;
  localparam int B_BUSY = 4;
  // control one
  localparam int B_CALSEL = 0;
  // control two
  localparam int B_PWR = 0;
  localparam int B_CAL = 2;
  localparam int B_CALINIT = 3;
  localparam int B_DMA = 8;
  localparam int B_ALIGN = 11;
  localparam int B_ISTART = 21;
  // sequence field positions
  localparam int B_RLEN = 16;
  localparam int B_ILEN = 16;
  // converter tick timing
  localparam logic [7:0] CONV_TICKS = 8'h0B;
  localparam logic [7:0] SMP_BASE = 8'h03;
  localparam logic [7:0] SMP_STEP = 8'h08;
  localparam logic [7:0] CALINIT_TICKS = 8'h04;
  localparam logic [7:0] CAL_TICKS = 8'h53;
  localparam logic [1:0] PRESC_RST = 2'h0;
  localparam logic [3:0] CH_VREF = 4'h8;
  localparam logic [3:0] CH_VCAL = 4'h9;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_IDLE = 3'b001,
    ST_CALINIT = 3'b010,
    ST_CAL = 3'b011,
    ST_SAMPLE = 3'b100,
    ST_CONV = 3'b101
  } adcsq_state_t;
endpackage

// *** core/adcsq_clkdiv.sv ***
// converter tick divider: one-cycle enable every 2*(prescale+1) clocks
`timescale 1ns/1ps
`default_nettype none
module adcsq_clkdiv (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic run,
  input wire logic [1:0] prescale,
  // tick out
  output logic tick
);
  import adcsq_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } adcsq_div_t;

  adcsq_div_t s;
  adcsq_div_t n;

  always_comb begin
    n = s;
    n.tick = 1'b0;
    if (!run) begin
      n.cnt = 3'h0;
    // a prescale lowered mid-count must not let the counter wrap for a long gap
    end else if (s.cnt >= {prescale, 1'b1}) begin
      n.cnt = 3'h0;
      n.tick = 1'b1;
    end else begin
      n.cnt = s.cnt + 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;
endmodule
`default_nettype wire

// *** sim/adcsq_monitor.sv ***
// port checker for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adcsq_monitor import adcsq_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // converter and dma
  input wire logic ana_power,
  input wire logic [3:0] ana_channel,
  input wire logic ana_sample,
  input wire logic ana_convert,
  input wire logic ana_cal_run,
  input wire logic dma_ack,
  input wire logic dma_req
);
  logic wr_ph;
  logic [7:0] wa;
  logic [1:0] presc;
  logic [7:0] clen;
  logic brk;
  logic c2_wr;
  // any write during a conversion may abort it, so its length is not judged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      wa <= 8'h00;
      presc <= 2'h0;
      clen <= 8'h00;
      brk <= 1'b0;
    end else begin
      wr_ph <= hsel && htrans[1] && hready && hwrite;
      wa <= {haddr[7:2], 2'h0};
      if (wr_ph && wa == OFS_PRESC) begin
        presc <= hwdata[1:0];
      end
      clen <= ana_convert ? clen + 8'h01 : 8'h00;
      brk <= ana_convert && (brk || wr_ph);
    end
  end
  assign c2_wr = wr_ph && wa == OFS_CTRL2;
  ////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus stall");
  off_quiet_a: assert property (!ana_power && !$past(ana_power) |->
    !(ana_sample || ana_convert || ana_cal_run)) else $error("active unpowered");
  off_write_a: assert property (c2_wr && !hwdata[0] |->
    ##2 !(ana_power || ana_sample || ana_convert)) else $error("no abort");
  cold_start_a: assert property (c2_wr && hwdata[0] && !ana_power |=>
    (!ana_sample && !ana_cal_run) [*4]) else $error("start while off");
  conv_len_a: assert property ($fell(ana_convert) && !brk |->
    clen == 8'h16 * ({6'h00, presc} + 8'h01)) else $error("conv length");
  conv_order_a: assert property ($rose(ana_convert) |-> $past(ana_sample)) else $error("no sample");
  chan_range_a: assert property (ana_channel <= 4'h9) else $error("bad channel");
  dma_cause_a: assert property ($rose(dma_req) |->
    $past(ana_convert) || $past(ana_convert, 2)) else $error("stray dma");
  dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req) else $error("dma dropped");
  dma_drop_a: assert property ($fell(dma_req) |-> $past(dma_ack)) else $error("dma unacked");
  cover property ($rose(dma_req));
  cover property ($fell(ana_cal_run));
  cover property ($fell(ana_convert) && brk);
endmodule
bind adcsq_top adcsq_monitor u_adcsq_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .ana_power(ana_power), .ana_channel(ana_channel),
  .ana_sample(ana_sample), .ana_convert(ana_convert), .ana_cal_run(ana_cal_run),
  .dma_ack(dma_ack), .dma_req(dma_req));
`default_nettype wire

// *** sim/adcsq_far_model.sv ***
// far side model: analog front end and dma acknowledge
`timescale 1ns/1ps
`default_nettype none
module adcsq_far_model #(
  parameter logic [9:0] CAL_CODE = 10'h15A,
  parameter int ACK_DLY = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // analog side
  input wire logic ana_power,
  input wire logic [3:0] ana_channel,
  input wire logic ana_cal_run,
  output logic [adcsq_pkg::RES_W-1:0] ana_result,
  // dma side
  input wire logic dma_req,
  output logic dma_ack,
  output logic [7:0] ack_count
);
  logic [9:0] idle_pat;
  int wcnt;
  // unpowered front end toggles so no stale code survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_pat <= 10'h2AA;
    end else begin
      idle_pat <= ~idle_pat;
    end
  end
  // distinct code per source, internal ones included
  assign ana_result = !ana_power ? idle_pat : ana_cal_run ? CAL_CODE : 10'h0A5 ^ {ana_channel, 6'h00};
  // channel is set up before the enable, so it acks after a fixed wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_ack <= 1'b0;
      wcnt <= 0;
      ack_count <= 8'h00;
    end else if (dma_req && !dma_ack && wcnt == ACK_DLY) begin
      dma_ack <= 1'b1;
      wcnt <= 0;
      ack_count <= ack_count + 8'h01;
    end else begin
      dma_ack <= 1'b0;
      wcnt <= (dma_req && !dma_ack) ? wcnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// register-level bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adcsq_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, ana_power, ana_sample, ana_convert, ana_cal_run, ana_cal_level;
  logic dma_req, dma_ack;
  logic [3:0] ana_channel;
  logic [9:0] ana_result;
  logic [7:0] acks, a0;
  int err_total = 0;
  int cmp_count = 0;
  int n, k;
  always #12.5 hclk = ~hclk;
  adcsq_top u_adcsq_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ana_result(ana_result),
    .ana_power(ana_power), .ana_channel(ana_channel), .ana_sample(ana_sample),
    .ana_convert(ana_convert), .ana_cal_run(ana_cal_run), .ana_cal_level(ana_cal_level),
    .dma_ack(dma_ack), .dma_req(dma_req));
  adcsq_far_model u_adcsq_far_model (.hclk(hclk), .hresetn(hresetn), .ana_power(ana_power),
    .ana_channel(ana_channel), .ana_cal_run(ana_cal_run), .ana_result(ana_result),
    .dma_req(dma_req), .dma_ack(dma_ack), .ack_count(acks));
  ////////////////////////////////////////
  function automatic logic [9:0] code(input logic [3:0] ch);
    return 10'h0A5 ^ {ch, 6'h00};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic waitrdy;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    waitrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitrdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    bus(1'b0, a, 32'h0);
    chk(rd & m, v);
  endtask
  // polling is bounded; running out ends the run
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int p;
    p = 0;
    do begin
      bus(1'b0, a, 32'h0);
      p++;
    end while ((rd & m) !== v && p < 300);
    chk(rd & m, v);
    if ((rd & m) !== v) finish_test();
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(OFS_CTRL2, 32'hFFFFFFFF, 32'h0);
    wr(8'h4C, 32'h5A5A5A5A);
    rdc(8'h4C, 32'hFFFFFFFF, 32'h0);
    wr(OFS_CTRL2, 32'hD);
    // stabilize and two converter clocks before calibrating
    repeat (8) @(posedge hclk);
    chk({29'h0, ana_power, ana_sample, ana_cal_run}, 32'h4);
    rdc(OFS_CTRL2, 32'hD, 32'h1);
    $display("test power end");
    wr(OFS_CTRL1, 32'h1);
    #1;
    chk({31'h0, ana_cal_level}, 32'h1);
    // calibrate after power-up, before normal conversions
    wr(OFS_CTRL2, 32'h9);
    poll(OFS_CTRL2, 32'h8, 32'h0);
    poll(OFS_STATUS, 32'h10, 32'h0);
    wr(OFS_CTRL2, 32'h5);
    poll(OFS_CTRL2, 32'h4, 32'h0);
    rdc(OFS_RRES, 32'hFFFFFFFF, 32'h15A);
    poll(OFS_STATUS, 32'h10, 32'h0);
    $display("test calibration end");
    wr(OFS_SMP1, 32'h0);
    wr(OFS_SMP2, 32'h0);
    wr(OFS_RSEQ3, 32'h83);
    wr(OFS_RSEQ1, 32'h10000);
    wr(OFS_STATUS, 32'h0);
    a0 = acks;
    wr(OFS_CTRL2, 32'h101);
    poll(OFS_STATUS, 32'h12, 32'h2);
    repeat (10) @(posedge hclk);
    chk({24'h0, acks - a0}, 32'h2);
    rdc(OFS_RRES, 32'hFFFFFFFF, {22'h0, code(4'h8)});
    $display("test regular end");
    wr(OFS_PRESC, 32'h1);
    wr(OFS_SMP2, 32'h400);
    wr(OFS_RSEQ1, 32'h0);
    wr(OFS_CTRL2, 32'h801);
    k = 0;
    while (ana_sample !== 1'b1 && k < 40) begin
      @(posedge hclk);
      k++;
    end
    k = 0;
    while (ana_sample === 1'b1 && k < 200) begin
      @(posedge hclk);
      k++;
    end
    chk({31'h0, k >= 73 && k <= 76}, 32'h1);
    poll(OFS_STATUS, 32'h10, 32'h0);
    rdc(OFS_RRES, 32'hFFFFFFFF, {16'h0, code(4'h3), 6'h00});
    $display("test align end");
    wr(OFS_PRESC, 32'h0);
    wr(OFS_ISEQ, 32'h9);
    wr(OFS_IOFS0, {22'h0, code(4'h9) + 10'h005});
    wr(OFS_STATUS, 32'h0);
    a0 = acks;
    wr(OFS_CTRL2, 32'h200101);
    poll(OFS_STATUS, 32'h4, 32'h4);
    rdc(OFS_IRES0, 32'hFFFFFFFF, 32'hFFFB);
    chk({24'h0, acks - a0}, 32'h0);
    poll(OFS_STATUS, 32'h10, 32'h0);
    wr(OFS_STATUS, 32'h0);
    wr(OFS_CTRL2, 32'h200901);
    poll(OFS_STATUS, 32'h4, 32'h4);
    rdc(OFS_IRES0, 32'hFFFFFFFF, 32'hFF60);
    poll(OFS_STATUS, 32'h10, 32'h0);
    $display("test injected end");
    wr(OFS_CTRL2, 32'h1);
    // abort must hit the conversion phase, where a missed restart shows on the pins
    k = 0;
    while (ana_convert !== 1'b1 && k < 100) begin
      @(posedge hclk);
      k++;
    end
    chk({31'h0, ana_convert}, 32'h1);
    wr(OFS_RSEQ3, 32'h5);
    #1;
    chk({30'h0, ana_sample, ana_convert}, 32'h2);
    poll(OFS_STATUS, 32'h10, 32'h0);
    rdc(OFS_RRES, 32'hFFFFFFFF, {22'h0, code(4'h5)});
    wr(OFS_CTRL2, 32'h1);
    repeat (10) @(posedge hclk);
    wr(OFS_CTRL2, 32'h0);
    repeat (3) @(posedge hclk);
    #1;
    chk({29'h0, ana_power, ana_sample, ana_convert}, 32'h0);
    rdc(OFS_STATUS, 32'h10, 32'h0);
    $display("test abort end");
    finish_test();
  end
endmodule
`default_nettype wire
